// File: cms_supervisor.sv
// Mode and safety supervisor: gates ciphertext, selects keys, runs alarm checks.
// Assumes front-panel inputs are synchronous; the engine answers each check
// start with one chk_done_in pulse carrying chk_pass_in.
//
// The implementer's own choices: the APB register port and the address map.
module cms_supervisor
    import cms_pkg::*;
#(
    parameter int unsigned NF         = 4,
    parameter bit          SINGLE_GEN = 1'b1
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [ADDR_W-1:0]     paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    input  wire logic                  lock_in,
    input  wire logic                  zeroize_in,
    input  wire logic                  power_off_in,
    input  wire logic                  maint_override_in,
    input  wire logic                  key_entry_in,
    input  wire logic                  key_parity_err_in,
    input  wire logic                  key_good_in,
    input  wire logic [NF-1:0]         fault_in,
    input  wire logic                  chk_done_in,
    input  wire logic                  chk_pass_in,
    input  wire logic                  iv_load_in,
    input  wire logic                  iv_ok_a_in,
    input  wire logic                  iv_ok_b_in,
    input  wire logic                  tx_start_in,
    output logic                       ct_enable_out,
    output logic                       traffic_en_out,
    output logic                       engine_en_out,
    output logic                       key_sel_test_out,
    output logic                       bypass_out,
    output logic                       zeroize_out,
    output logic                       iv_zeroize_out,
    output logic                       key_xfer_block_out,
    output logic                       chk_start_out,
    output logic                       sbox_run_out,
    output logic [NF+ASRC_FIXED-1:0]   chk_mask_out,
    output logic                       ind_test_out,
    output logic                       ind_alarm_out,
    output logic                       ind_parity_out,
    output logic                       ind_bypass_out,
    output logic                       ind_power_out
);

    localparam int unsigned NA = NF + ASRC_FIXED;

    typedef struct packed {
        cms_state_t          st;
        cms_mode_t           mode;
        logic                lamp;
        logic                cbc;
        logic                arst;
        logic [NA-1:0]       asrc;
        logic                chk_test;
        logic                chk_start;
        logic [NA-1:0]       chk_mask;
        logic                ovr;
        logic [ZCNT_W-1:0]   zcnt;
        logic                parity;
        logic                iv_fresh;
        logic                inh_a;
        logic                inh_b;
        logic [31:0]         prdata;
    } cms_regs_t;

    cms_regs_t   s;
    cms_regs_t   next_s;
    logic [1:0]  rst_sync;
    logic        rst_n;
    logic        wr;
    logic        setup;
    logic        mapped;
    logic        zero_req;
    logic [NA-1:0] new_src;
    logic        raise;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign setup  = psel_in && !penable_in;
    assign wr     = psel_in && penable_in && pwrite_in;
    assign mapped = (paddr_in == ADDR_CTRL) || (paddr_in == ADDR_STATUS)
                    || (paddr_in == ADDR_ALARM);
    // Zero wait states: every access completes in its first access cycle
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // Register write bit or panel switch; neither needs the lock
    assign zero_req = zeroize_in || power_off_in
                      || (wr && paddr_in == ADDR_CTRL && pwdata_in[CTRL_ZERO_BIT]);

    always_comb begin
        new_src = '0;
        new_src[ASRC_DISAGREE] = s.inh_a != s.inh_b;
        new_src[ASRC_IV] = (s.st == ST_SEC)
                           && ((iv_load_in && (iv_ok_a_in != iv_ok_b_in))
                               || (tx_start_in && !s.iv_fresh));
        new_src[NA-1:ASRC_FIXED] = fault_in;
    end
    // Faults during a check are the exercise itself, not new alarms
    assign raise = (|new_src) && (s.st != ST_CHK) && (s.st != ST_ZERO);

    always_comb begin
        next_s           = s;
        next_s.arst      = 1'b0;
        next_s.chk_start = 1'b0;

        // Lock-gated fields take effect only with the operator lock open
        // No control register write is taken while an erase pass runs; reads are still answered
        if (wr && paddr_in == ADDR_CTRL && s.st != ST_ZERO) begin
            next_s.lamp = pwdata_in[CTRL_LAMP_BIT];
            if (lock_in) begin
                next_s.mode = cms_mode_t'(pwdata_in[CTRL_MODE_LSB +: 2]);
                next_s.arst = pwdata_in[CTRL_ARST_BIT];
                next_s.cbc  = pwdata_in[CTRL_CBC_BIT];
            end
        end

        // Set wins over clear
        if (key_parity_err_in) begin
            next_s.parity = 1'b1;
        end else if (key_good_in) begin
            next_s.parity = 1'b0;
        end
        if (tx_start_in) begin
            next_s.iv_fresh = 1'b0;
        end
        if (iv_load_in && iv_ok_a_in && iv_ok_b_in) begin
            next_s.iv_fresh = 1'b1;
        end

        if (raise) begin
            next_s.asrc = s.asrc | new_src;
        end

        if (s.st == ST_ZERO) begin
            // One whole pass; no other control is looked at meanwhile
            if (s.zcnt == ZCNT_W'(ZERO_CYC - 1)) begin
                next_s.st = ST_STBY;
            end else begin
                next_s.zcnt = s.zcnt + ZCNT_W'(1);
            end
        end else if (zero_req) begin
            next_s.st       = ST_ZERO;
            next_s.zcnt     = '0;
            next_s.iv_fresh = 1'b0;
            next_s.ovr      = 1'b0;
        end else if (raise && s.st != ST_BYP && s.st != ST_ALARM) begin
            // In alarm the sources still latch, but bypass and reset stay reachable
            next_s.st  = ST_ALARM;
            next_s.ovr = 1'b0;
        end else begin
            case (s.st)
                ST_STBY, ST_SEC: begin
                    case (s.mode)
                        MODE_STBY: next_s.st = ST_STBY;
                        MODE_SEC:  next_s.st = ST_SEC;
                        MODE_BYP:  next_s.st = ST_BYP;
                        default: begin
                            next_s.st        = ST_CHK;
                            next_s.chk_test  = 1'b1;
                            next_s.chk_start = 1'b1;
                            next_s.chk_mask  = '1;
                        end
                    endcase
                end
                ST_TEST: begin
                    next_s.ovr = maint_override_in;
                    if (s.mode != MODE_TEST) begin
                        next_s.ovr = 1'b0;
                        // Leave only once the override is already down
                        if (!s.ovr) begin
                            next_s.st = ST_STBY;
                        end
                    end
                end
                ST_CHK: begin
                    if (chk_done_in) begin
                        if (chk_pass_in) begin
                            next_s.st   = s.chk_test ? ST_TEST : ST_STBY;
                            next_s.asrc = '0;
                        end else begin
                            next_s.st = ST_ALARM;
                            next_s.asrc[ASRC_SELF] = 1'b1;
                        end
                    end
                end
                ST_ALARM: begin
                    if (s.mode == MODE_BYP) begin
                        next_s.st = ST_BYP;
                    end else if (s.arst) begin
                        next_s.st        = ST_CHK;
                        next_s.chk_test  = 1'b0;
                        next_s.chk_start = 1'b1;
                        next_s.chk_mask  = s.asrc;
                    end
                end
                ST_BYP: begin
                    if (s.mode != MODE_BYP) begin
                        next_s.st = (|s.asrc) ? ST_ALARM : ST_STBY;
                    end
                end
                default: next_s.st = ST_ZERO;
            endcase
        end

        // Two independently decoded inhibit copies, compared every cycle
        next_s.inh_a = (next_s.st == ST_TEST && !next_s.ovr)
                       || next_s.st == ST_ALARM || next_s.st == ST_CHK
                       || next_s.st == ST_STBY || next_s.st == ST_ZERO
                       || next_s.st == ST_BYP;
        next_s.inh_b = !(next_s.st == ST_SEC
                         || (next_s.st == ST_TEST && next_s.ovr));

        next_s.prdata = '0;
        if (setup) begin
            case (paddr_in)
                ADDR_CTRL: begin
                    next_s.prdata[CTRL_MODE_LSB +: 2] = s.mode;
                    next_s.prdata[CTRL_LAMP_BIT]      = s.lamp;
                    next_s.prdata[CTRL_CBC_BIT]       = s.cbc;
                end
                ADDR_STATUS: begin
                    next_s.prdata[STAT_ST_LSB +: 3]   = s.st;
                    next_s.prdata[STAT_OVR_BIT]       = s.ovr;
                    next_s.prdata[STAT_PAR_BIT]       = s.parity;
                    next_s.prdata[STAT_IV_BIT]        = s.iv_fresh;
                    next_s.prdata[STAT_ALM_BIT]       = |s.asrc;
                    next_s.prdata[STAT_LAMP_BIT]      = s.lamp;
                    next_s.prdata[STAT_CBC_BIT]       = s.cbc;
                    next_s.prdata[STAT_MODE_LSB +: 2] = s.mode;
                end
                ADDR_ALARM: next_s.prdata[NA-1:0] = s.asrc;
                default:    next_s.prdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s          <= '0;
            s.st       <= ST_STBY;
            s.mode     <= MODE_STBY;
            s.inh_a    <= 1'b1;
            s.inh_b    <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_out = s.prdata;

    // Raw faults and key entry gate the output combinationally, not a cycle late
    assign ct_enable_out = !s.inh_a && !s.inh_b && !(|fault_in)
                           && !key_entry_in;
    assign key_sel_test_out = s.st == ST_TEST || (s.st == ST_CHK && s.chk_test);
    assign traffic_en_out   = s.st == ST_SEC && !key_sel_test_out;
    assign engine_en_out    = s.st == ST_SEC || s.st == ST_TEST || s.st == ST_CHK;
    assign bypass_out       = s.st == ST_BYP;
    assign zeroize_out      = s.st == ST_ZERO;
    assign iv_zeroize_out   = s.st == ST_ZERO && s.cbc;
    assign key_xfer_block_out = s.parity;
    assign chk_start_out    = s.chk_start;
    assign sbox_run_out     = s.chk_start && s.chk_test && SINGLE_GEN;
    assign chk_mask_out     = s.chk_mask;
    assign ind_test_out     = s.lamp || key_sel_test_out;
    assign ind_alarm_out    = s.lamp || (|s.asrc);
    assign ind_parity_out   = s.lamp || s.parity;
    assign ind_bypass_out   = s.lamp || bypass_out;
    assign ind_power_out    = s.lamp || !power_off_in;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    test_inhibit_a: assert property (s.st == ST_TEST && !s.ovr |-> !ct_enable_out)
        else $error("ciphertext enabled in test without override");
    test_entry_a: assert property (
        ((s.st == ST_SEC || s.st == ST_STBY) && s.mode == MODE_TEST && !zero_req && !raise)
        |=> s.st == ST_CHK && chk_start_out && chk_mask_out == '1
            && sbox_run_out == SINGLE_GEN)
        else $error("test entry did not start full checks");
    test_key_a: assert property (s.st == ST_TEST |-> key_sel_test_out && !traffic_en_out)
        else $error("test mode without test key");
    ovr_scope_a: assert property (s.ovr |-> s.st == ST_TEST)
        else $error("override outside test mode");
    ovr_exit_a: assert property ($past(s.st) == ST_TEST && s.st == ST_STBY |-> !$past(s.ovr))
        else $error("left test with override set");
    live_key_a: assert property (traffic_en_out |-> !key_sel_test_out && s.st == ST_SEC)
        else $error("test key on live traffic");
    reset_check_a: assert property (
        s.st == ST_ALARM && s.arst && s.mode != MODE_BYP && !zero_req
        |=> s.st == ST_CHK && chk_start_out && chk_mask_out == $past(s.asrc))
        else $error("alarm reset did not rerun its checks");
    check_fail_a: assert property (
        s.st == ST_CHK && chk_done_in && !chk_pass_in && !zero_req
        |=> s.st == ST_ALARM [*2] or (s.st == ST_ALARM ##1 s.st != ST_SEC))
        else $error("failed check left alarm state");
    alarm_inh_a: assert property (s.st == ST_ALARM |-> !ct_enable_out)
        else $error("ciphertext enabled in alarm");
    zero_pass_a: assert property (
        power_off_in && s.st != ST_ZERO |=> zeroize_out [*8])
        else $error("power off did not zeroize");
    standby_a: assert property (s.st == ST_STBY |-> !engine_en_out && !zeroize_out)
        else $error("standby left engine running or erased key");
    keyent_a: assert property (key_entry_in |-> !ct_enable_out)
        else $error("ciphertext during key entry");
    fault_now_a: assert property ((|fault_in) |-> !ct_enable_out)
        else $error("fault did not gate output at once");
    parity_blk_a: assert property (key_parity_err_in |=> key_xfer_block_out)
        else $error("parity error did not block transfers");

    recover_c: cover property (s.st == ST_CHK && !s.chk_test ##1 s.st == ST_STBY);
    test_c:    cover property (s.st == ST_CHK ##1 s.st == ST_TEST);
    zero_c:    cover property (s.st == ST_ZERO ##1 s.st == ST_STBY);
    bypass_c:  cover property (s.st == ST_ALARM ##1 s.st == ST_BYP);

endmodule

// File: cms_pkg.sv
// Constants, register map and state encodings for the cipher mode supervisor.
// Assumes a single 50 MHz equipment clock and an APB master with 32-bit data.
package cms_pkg;

    localparam int unsigned ADDR_W = 12;

    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_ALARM  = 12'h008;

    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_ARST_BIT = 2;
    localparam int unsigned CTRL_ZERO_BIT = 3;
    localparam int unsigned CTRL_LAMP_BIT = 4;
    localparam int unsigned CTRL_CBC_BIT  = 5;

    localparam int unsigned STAT_ST_LSB   = 0;
    localparam int unsigned STAT_OVR_BIT  = 3;
    localparam int unsigned STAT_PAR_BIT  = 4;
    localparam int unsigned STAT_IV_BIT   = 5;
    localparam int unsigned STAT_ALM_BIT  = 6;
    localparam int unsigned STAT_LAMP_BIT = 7;
    localparam int unsigned STAT_CBC_BIT  = 8;
    localparam int unsigned STAT_MODE_LSB = 9;

    // Alarm source bits; external faults follow the fixed ones
    localparam int unsigned ASRC_DISAGREE = 0;
    localparam int unsigned ASRC_IV       = 1;
    localparam int unsigned ASRC_SELF     = 2;
    localparam int unsigned ASRC_FIXED    = 3;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned ZERO_TIME_NS  = 1000;
    localparam int unsigned ZERO_CYC      = (ZERO_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ZCNT_W        = 8;

    typedef enum logic [1:0] {
        MODE_STBY = 2'h0,
        MODE_SEC  = 2'h1,
        MODE_TEST = 2'h2,
        MODE_BYP  = 2'h3
    } cms_mode_t;

    // Gray along standby, secure, test, check, alarm
    typedef enum logic [2:0] {
        ST_STBY  = 3'h0,
        ST_SEC   = 3'h1,
        ST_TEST  = 3'h3,
        ST_CHK   = 3'h2,
        ST_ALARM = 3'h6,
        ST_BYP   = 3'h7,
        ST_ZERO  = 3'h4
    } cms_state_t;

endpackage

// File: cms_panel_model.sv
// Operator panel model: lock key switch and the unlocked zeroize button.
// Assumes the bench asks for lock and zeroize as levels; both change on clk_in edges.
module cms_panel_model (
    input  wire logic clk_in,
    input  wire logic want_open_in,
    input  wire logic want_zero_in,
    output logic      lock_out,
    output logic      zeroize_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // One shared key switch gates every locked control
    always @(posedge clk_in) begin
        lock_out    <= want_open_in;
        zeroize_out <= want_zero_in;
    end
endmodule

// File: cms_tb.sv
// Self-checking bench for the cipher mode supervisor, APB master plus panel.
// Assumes zero-wait APB and one chk_done_in answer to each check start.
module tb import cms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, psel, pen, pwr, pready, pslverr, er, want_open, want_zero, lock, zero_in;
    logic pwr_off, maint, kentry, perr, kgood, cdone, cpass, ct, traf, eng, ktest, byp;
    logic zout, ivz, xblk, cstart, sbox, ivld, txs;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rv;
    logic [3:0]        fault;
    logic [6:0]        cmask;
    logic [4:0]        ind;
    int                err_count, total_checks, cycles;
    cms_panel_model cms_panel_model_inst (.clk_in(clk), .want_open_in(want_open),
        .want_zero_in(want_zero), .lock_out(lock), .zeroize_out(zero_in));
    cms_supervisor #(.NF(4), .SINGLE_GEN(1'b1)) cms_supervisor_inst (.clk_in(clk),
        .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .lock_in(lock), .zeroize_in(zero_in), .power_off_in(pwr_off), .maint_override_in(maint),
        .key_entry_in(kentry), .key_parity_err_in(perr), .key_good_in(kgood),
        .fault_in(fault), .chk_done_in(cdone), .chk_pass_in(cpass), .iv_load_in(ivld),
        .iv_ok_a_in(1'b1), .iv_ok_b_in(1'b1), .tx_start_in(txs), .ct_enable_out(ct),
        .traffic_en_out(traf), .engine_en_out(eng), .key_sel_test_out(ktest),
        .bypass_out(byp), .zeroize_out(zout), .iv_zeroize_out(ivz),
        .key_xfer_block_out(xblk), .chk_start_out(cstart), .sbox_run_out(sbox),
        .chk_mask_out(cmask), .ind_test_out(ind[4]), .ind_alarm_out(ind[3]),
        .ind_parity_out(ind[2]), .ind_bypass_out(ind[1]), .ind_power_out(ind[0]));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test;
        end
    end
    task automatic cw(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cb(input logic got, input logic exp);
        cw({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] d);
        apb(1'b1, ADDR_CTRL, d);
        cyc(4);
    endtask
    task automatic key(input logic v);
        want_open <= v;
        cyc(2);
    endtask
    // Waits for the check start pulse, then answers it the next cycle
    task automatic answer(input logic pass, input logic [31:0] mask, input logic sb);
        int n;
        n = 0;
        while (cstart !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        cb(cstart, 1'b1);
        cw(32'(cmask), mask);
        cb(sbox, sb);
        cdone <= 1'b1;
        cpass <= pass;
        @(posedge clk);
        cdone <= 1'b0;
        cyc(3);
    endtask
    task automatic t_reset;
        cb(ct, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        cw(rv, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        cb(er, 1'b1);
        cw(rv, 32'h0000_0000);
        $display("reset test done");
    endtask
    task automatic t_secure;
        key(1'b1);
        wr(32'h0000_0001);
        cb(traf, 1'b1);
        cb(ct, 1'b1);
        cb(ktest, 1'b0);
        kentry <= 1'b1;
        cyc(2);
        cb(ct, 1'b0);
        kentry <= 1'b0;
        key(1'b0);
        wr(32'h0000_0002);
        cb(traf, 1'b1);
        cb(ct, 1'b1);
        $display("secure test done");
    endtask
    task automatic t_alarm;
        fault <= 4'h1;
        @(posedge clk);
        cb(ct, 1'b0);
        cyc(2);
        cb(ind[3], 1'b1);
        apb(1'b0, ADDR_ALARM, 32'h0000_0000);
        cw(rv, 32'h0000_0008);
        key(1'b1);
        wr(32'h0000_0003);
        cb(byp, 1'b1);
        cb(ind[1], 1'b1);
        wr(32'h0000_0000);
        cb(byp, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0004);
        answer(1'b0, 32'h0000_0008, 1'b0);
        cb(ind[3], 1'b1);
        cb(ct, 1'b0);
        fault <= 4'h0;
        apb(1'b1, ADDR_CTRL, 32'h0000_0004);
        answer(1'b1, 32'h0000_000c, 1'b0);
        cb(ind[3], 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        cw(32'(rv[2:0]), 32'(ST_STBY));
        $display("alarm test done");
    endtask
    task automatic t_test;
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        answer(1'b1, 32'h0000_007f, 1'b1);
        cb(ktest, 1'b1);
        cb(ct, 1'b0);
        cb(traf, 1'b0);
        maint <= 1'b1;
        cyc(3);
        cb(ct, 1'b1);
        wr(32'h0000_0001);
        cyc(3);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        cb(rv[STAT_OVR_BIT], 1'b0);
        cb(ktest, 1'b0);
        kentry <= 1'b1;
        cyc(2);
        cb(ct, 1'b0);
        kentry <= 1'b0;
        maint <= 1'b0;
        $display("test mode test done");
    endtask
    task automatic t_iv;
        ivld <= 1'b1;
        @(posedge clk);
        ivld <= 1'b0;
        txs  <= 1'b1;
        @(posedge clk);
        txs <= 1'b0;
        cyc(2);
        cb(ind[3], 1'b0);
        cb(ct, 1'b1);
        // A second start finds the IV already spent
        txs <= 1'b1;
        @(posedge clk);
        txs <= 1'b0;
        cyc(2);
        cb(ind[3], 1'b1);
        cb(ct, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0005);
        answer(1'b1, 32'h0000_0002, 1'b0);
        cb(ind[3], 1'b0);
        $display("iv test done");
    endtask
    task automatic t_park;
        wr(32'h0000_0000);
        cb(eng, 1'b0);
        cb(zout, 1'b0);
        perr <= 1'b1;
        @(posedge clk);
        perr <= 1'b0;
        cyc(2);
        cb(xblk, 1'b1);
        kgood <= 1'b1;
        @(posedge clk);
        kgood <= 1'b0;
        cyc(2);
        cb(xblk, 1'b0);
        $display("standby test done");
    endtask
    task automatic t_zero;
        wr(32'h0000_0021);
        key(1'b0);
        want_zero <= 1'b1;
        cyc(2);
        want_zero <= 1'b0;
        cyc(2);
        cb(zout, 1'b1);
        cb(ivz, 1'b1);
        cb(ct, 1'b0);
        key(1'b1);
        wr(32'h0000_0002);
        cyc(60);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        cw(32'(rv[10:9]), 32'(MODE_SEC));
        pwr_off <= 1'b1;
        cyc(3);
        cb(zout, 1'b1);
        pwr_off <= 1'b0;
        cyc(60);
        key(1'b0);
        wr(32'h0000_0010);
        cw(32'(ind), 32'h0000_001f);
        $display("zeroize and lamp test done");
    endtask
    initial begin
        {psel, pen, pwr, want_open, want_zero, pwr_off, maint, kentry} = 8'h00;
        {perr, kgood, cdone, cpass, ivld, txs} = 6'h00;
        paddr = '0;
        pwdata = 32'h0000_0000;
        fault = 4'h0;
        err_count = 0;
        total_checks = 0;
        cycles = 0;
        rst_b = 1'b0;
        cyc(4);
        rst_b <= 1'b1;
        cyc(4);
        t_reset;
        t_secure;
        t_alarm;
        t_test;
        t_iv;
        t_park;
        t_zero;
        finish_test;
    end
endmodule
